// ---- sqd_pkg.sv ----
// Shared constants for the queued send log-write decoder and its host
//
// Function
// - Command code 64h means queued send
// - Subcommand 2h is log write; others reserved
// - Parameters and responses depend on subcommand
// - Subcommand sits in feature current bits 4:0
// - Count low in feature current, high previous
// - LBA 23:0 from current address bytes
// - LBA 47:24 from previous address bytes
// - Completed tags reported in SDB ACT field
// - Pre-acceptance errors reported by register FIS
package sqd_pkg;
  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  localparam logic [7:0] SQD_CMD_SEND = 8'h64;
  localparam logic [4:0] SQD_SUB_LOGWR = 5'h02;
  localparam int SQD_SUB_LSB = 0;
  localparam int SQD_TAG_LSB = 3;
  localparam int SQD_TAGS = 32;
  // ----------------------------------------------------------------
  // Status and error byte fields
  // ----------------------------------------------------------------
  localparam int SQD_ST_BSY = 7;
  localparam int SQD_ST_RDY = 6;
  localparam int SQD_ST_DF = 5;
  localparam int SQD_ST_DRQ = 3;
  localparam int SQD_ST_ERR = 0;
  localparam logic [7:0] SQD_ER_ABT = 8'h04;
  localparam logic [7:0] SQD_ER_MASK = 8'hD4;
  localparam logic [7:0] SQD_DEV_HEAD = 8'h40;
  // ----------------------------------------------------------------
  // Host register map (AHB-Lite byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] SQD_A_CMD = 8'h00;
  localparam logic [7:0] SQD_A_TAGCNT = 8'h04;
  localparam logic [7:0] SQD_A_LBALO = 8'h08;
  localparam logic [7:0] SQD_A_LBAHI = 8'h0C;
  localparam logic [7:0] SQD_A_ISSUE = 8'h10;
  localparam logic [7:0] SQD_A_STAT = 8'h14;
  localparam logic [7:0] SQD_A_DONE = 8'h18;
  localparam logic [7:0] SQD_A_ISTAT = 8'h1C;
  localparam logic [7:0] SQD_A_IEN = 8'h20;
  localparam logic [7:0] SQD_A_ICLR = 8'h24;
  localparam logic [12:0] SQD_CMD_RST = 13'h0264;
  localparam int SQD_EV_ACC = 0;
  localparam int SQD_EV_ERR = 1;
  localparam int SQD_EV_SDB = 2;
  localparam int SQD_NEV = 3;
endpackage

// ---- sqd_if.sv ----
// Link between host controller and device command layer
`timescale 1ns/100ps
`default_nettype none
interface sqd_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] cmd_code;
  logic [7:0] feat_cur;
  logic [7:0] feat_prev;
  logic [7:0] scnt_cur;
  logic [7:0] scnt_prev;
  logic [7:0] snum_cur;
  logic [7:0] snum_prev;
  logic [7:0] cyllo_cur;
  logic [7:0] cyllo_prev;
  logic [7:0] cylhi_cur;
  logic [7:0] cylhi_prev;
  logic [7:0] dev_head;
  logic reg_fis_valid;
  logic sdb_valid;
  logic [7:0] fis_status;
  logic [7:0] fis_error;
  logic [31:0] sdb_act;
  modport dev (
    input cmd_valid, cmd_code, feat_cur, feat_prev, scnt_cur, scnt_prev,
    input snum_cur, snum_prev, cyllo_cur, cyllo_prev, cylhi_cur,
    input cylhi_prev, dev_head,
    output cmd_ready, reg_fis_valid, sdb_valid, fis_status, fis_error,
    output sdb_act
  );
  modport host (
    output cmd_valid, cmd_code, feat_cur, feat_prev, scnt_cur, scnt_prev,
    output snum_cur, snum_prev, cyllo_cur, cyllo_prev, cylhi_cur,
    output cylhi_prev, dev_head,
    input cmd_ready, reg_fis_valid, sdb_valid, fis_status, fis_error,
    input sdb_act
  );
endinterface
`default_nettype wire

// ---- sqd_dev.sv ----
// Device command layer: decodes queued send log write, reports by FIS
`timescale 1ns/100ps
`default_nettype none
module sqd_dev
  import sqd_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  sqd_if.dev LNK,
  output logic OP_VALID,
  output logic [4:0] OP_TAG,
  output logic [15:0] OP_COUNT,
  output logic [47:0] OP_LBA,
  input wire logic DONE_VALID,
  input wire logic [4:0] DONE_TAG,
  input wire logic DONE_FAIL,
  input wire logic [7:0] DONE_ERR,
  output logic [7:0] ERROR_FLAGS,
  output logic [7:0] STATUS_FLAGS,
  output logic [31:0] OUTSTANDING
);
  typedef enum logic [2:0] {
    SQD_IDLE = 3'b001,
    SQD_RFIS = 3'b010,
    SQD_SFIS = 3'b100
  } sqd_dstate_t;

  // ----------------------------------------------------------------
  // Decode of the presented command block
  // ----------------------------------------------------------------
  logic [4:0] sub_w;
  logic [4:0] tag_w;
  logic code_ok_w;
  logic sub_ok_w;
  logic tag_free_w;
  logic good_w;
  logic take_w;
  sqd_dstate_t state_q;
  logic [31:0] busy_q;
  logic [31:0] pend_q;
  logic fail_q;
  logic [7:0] fail_err_q;
  logic rfis_q;
  logic sfis_q;
  logic [7:0] stat_q;
  logic [7:0] err_q;
  logic [31:0] act_q;
  logic [31:0] done_bit_w;

  assign sub_w = LNK.feat_cur[SQD_SUB_LSB +: 5];
  assign tag_w = LNK.scnt_cur[SQD_TAG_LSB +: 5];
  assign code_ok_w = (LNK.cmd_code == SQD_CMD_SEND);
  // Any other subcommand is reserved and aborted
  assign sub_ok_w = (sub_w == SQD_SUB_LOGWR);
  assign tag_free_w = ~busy_q[tag_w];
  // Acceptance needs the send code, the log-write subcommand and a free tag
  assign good_w = code_ok_w & sub_ok_w & tag_free_w;
  assign take_w = LNK.cmd_valid & (state_q == SQD_IDLE);
  assign LNK.cmd_ready = (state_q == SQD_IDLE);
  assign done_bit_w = 32'h00000001 << DONE_TAG;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      state_q <= SQD_IDLE;
    else
    begin
      case (state_q)
        SQD_IDLE:
        begin
          // Commands get priority; completions wait one slot
          if (LNK.cmd_valid)
            state_q <= SQD_RFIS;
          else if ((pend_q != 32'h00000000) || fail_q)
            state_q <= SQD_SFIS;
        end
        SQD_RFIS: state_q <= SQD_IDLE;
        SQD_SFIS: state_q <= SQD_IDLE;
        default: state_q <= SQD_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Parameter capture for the log-write operation
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      OP_VALID <= 1'b0;
      OP_TAG <= 5'h00;
      OP_COUNT <= 16'h0000;
      OP_LBA <= 48'h000000000000;
    end
    else
    begin
      OP_VALID <= take_w & good_w;
      if (take_w & good_w)
      begin
        OP_TAG <= tag_w;
        OP_COUNT <= {LNK.feat_prev, LNK.feat_cur};
        OP_LBA[23:0] <= {LNK.cylhi_cur, LNK.cyllo_cur,
                         LNK.snum_cur};
        OP_LBA[47:24] <= {LNK.cylhi_prev, LNK.cyllo_prev,
                          LNK.snum_prev};
      end
    end
  end

  // ----------------------------------------------------------------
  // Outstanding tags and completion accumulation
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      busy_q <= 32'h00000000;
    else
    begin
      // A tag frees on completion before it may be reissued
      if (DONE_VALID)
        busy_q[DONE_TAG] <= 1'b0;
      if (take_w & good_w)
        busy_q[tag_w] <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      pend_q <= 32'h00000000;
    else
    begin
      // Completion arriving while reporting is kept: set wins
      if ((state_q == SQD_SFIS) && DONE_VALID && !DONE_FAIL)
        pend_q <= done_bit_w;
      else if (state_q == SQD_SFIS)
        pend_q <= 32'h00000000;
      else if (DONE_VALID && !DONE_FAIL)
        pend_q <= pend_q | done_bit_w;
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      fail_q <= 1'b0;
      fail_err_q <= 8'h00;
    end
    else if (DONE_VALID && DONE_FAIL)
    begin
      fail_q <= 1'b1;
      // Bits already sent in this SDB must not be reported twice
      if (state_q == SQD_SFIS)
        fail_err_q <= DONE_ERR & SQD_ER_MASK;
      else
        fail_err_q <= fail_err_q | (DONE_ERR & SQD_ER_MASK);
    end
    else if (state_q == SQD_SFIS)
    begin
      fail_q <= 1'b0;
      fail_err_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // FIS generation
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      rfis_q <= 1'b0;
      sfis_q <= 1'b0;
      stat_q <= 8'h00;
      err_q <= 8'h00;
      act_q <= 32'h00000000;
    end
    else
    begin
      rfis_q <= take_w;
      sfis_q <= (state_q == SQD_SFIS);
      if (take_w)
      begin
        // BSY, DF, DRQ stay zero in every ending status
        stat_q <= 8'h00;
        stat_q[SQD_ST_RDY] <= 1'b1;
        stat_q[SQD_ST_ERR] <= ~good_w;
        err_q <= good_w ? 8'h00 : SQD_ER_ABT;
        act_q <= 32'h00000000;
      end
      else if (state_q == SQD_SFIS)
      begin
        stat_q <= 8'h00;
        stat_q[SQD_ST_RDY] <= 1'b1;
        stat_q[SQD_ST_ERR] <= fail_q;
        err_q <= fail_err_q;
        act_q <= pend_q;
      end
    end
  end

  assign LNK.reg_fis_valid = rfis_q;
  assign LNK.sdb_valid = sfis_q;
  assign LNK.fis_status = stat_q;
  assign LNK.fis_error = err_q;
  assign LNK.sdb_act = act_q;
  assign ERROR_FLAGS = err_q;
  assign STATUS_FLAGS = stat_q;
  assign OUTSTANDING = busy_q;
endmodule
`default_nettype wire

// ---- sqd_host.sv ----
// Host controller: AHB-Lite registers drive queued send commands
`timescale 1ns/100ps
`default_nettype none
module sqd_host
  import sqd_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  sqd_if.host LNK,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  output logic IRQ
);
  // ----------------------------------------------------------------
  // Bus slave, zero wait states
  // ----------------------------------------------------------------
  logic wr_q;
  logic [7:0] wa_q;
  logic acc_w;
  logic [12:0] cmd_q;
  logic [20:0] tagcnt_q;
  logic [31:0] lbalo_q;
  logic [15:0] lbahi_q;
  logic [31:0] done_q;
  logic [7:0] lst_q;
  logic [7:0] ler_q;
  logic [SQD_NEV-1:0] ist_q;
  logic [SQD_NEV-1:0] ien_q;
  logic [SQD_NEV-1:0] ev_w;
  logic vld_q;
  logic [15:0] cnt_w;

  assign acc_w = HSEL & HTRANS[1] & HREADY;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign cnt_w = tagcnt_q[20:5];

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end
    else
    begin
      wr_q <= acc_w & HWRITE;
      wa_q <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      HRDATA <= 32'h00000000;
    else if (acc_w & !HWRITE)
    begin
      case (HADDR[7:0])
        SQD_A_CMD: HRDATA <= {19'h00000, cmd_q};
        SQD_A_TAGCNT: HRDATA <= {11'h000, tagcnt_q};
        SQD_A_LBALO: HRDATA <= lbalo_q;
        SQD_A_LBAHI: HRDATA <= {16'h0000, lbahi_q};
        SQD_A_STAT: HRDATA <= {8'h00, ler_q, lst_q, 7'h00, vld_q};
        SQD_A_DONE: HRDATA <= done_q;
        SQD_A_ISTAT: HRDATA <= {29'h00000000, ist_q};
        SQD_A_IEN: HRDATA <= {29'h00000000, ien_q};
        default: HRDATA <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      cmd_q <= SQD_CMD_RST;
      tagcnt_q <= 21'h000000;
      lbalo_q <= 32'h00000000;
      lbahi_q <= 16'h0000;
      ien_q <= '0;
    end
    else if (wr_q)
    begin
      case (wa_q)
        SQD_A_CMD: cmd_q <= HWDATA[12:0];
        SQD_A_TAGCNT: tagcnt_q <= HWDATA[20:0];
        SQD_A_LBALO: lbalo_q <= HWDATA;
        SQD_A_LBAHI: lbahi_q <= HWDATA[15:0];
        SQD_A_IEN: ien_q <= HWDATA[SQD_NEV-1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command issue towards the device
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      vld_q <= 1'b0;
    else if (vld_q && LNK.cmd_ready)
      vld_q <= 1'b0;
    else if (wr_q && (wa_q == SQD_A_ISSUE) && HWDATA[0])
      vld_q <= 1'b1;
  end

  assign LNK.cmd_valid = vld_q;
  assign LNK.cmd_code = cmd_q[7:0];
  // Subcommand overlays count bits 4:0 in the shared byte
  assign LNK.feat_cur = {cnt_w[7:5], cmd_q[12:8]};
  assign LNK.feat_prev = cnt_w[15:8];
  assign LNK.scnt_cur = {tagcnt_q[4:0], 3'h0};
  assign LNK.scnt_prev = 8'h00;
  assign LNK.snum_cur = lbalo_q[7:0];
  assign LNK.cyllo_cur = lbalo_q[15:8];
  assign LNK.cylhi_cur = lbalo_q[23:16];
  assign LNK.snum_prev = lbalo_q[31:24];
  assign LNK.cyllo_prev = lbahi_q[7:0];
  assign LNK.cylhi_prev = lbahi_q[15:8];
  assign LNK.dev_head = SQD_DEV_HEAD;

  // ----------------------------------------------------------------
  // Responses and interrupts
  // ----------------------------------------------------------------
  assign ev_w[SQD_EV_ACC] = LNK.reg_fis_valid & ~LNK.fis_status[SQD_ST_ERR];
  assign ev_w[SQD_EV_ERR] = LNK.reg_fis_valid & LNK.fis_status[SQD_ST_ERR];
  assign ev_w[SQD_EV_SDB] = LNK.sdb_valid;

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      lst_q <= 8'h00;
      ler_q <= 8'h00;
    end
    else if (LNK.reg_fis_valid | LNK.sdb_valid)
    begin
      lst_q <= LNK.fis_status;
      ler_q <= LNK.fis_error;
    end
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      done_q <= 32'h00000000;
    else if (wr_q && (wa_q == SQD_A_DONE))
      done_q <= (done_q & ~HWDATA) | (LNK.sdb_valid ? LNK.sdb_act : '0);
    else if (LNK.sdb_valid)
      done_q <= done_q | LNK.sdb_act;
  end

  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
      ist_q <= '0;
    else if (wr_q && (wa_q == SQD_A_ICLR))
      ist_q <= (ist_q & ~HWDATA[SQD_NEV-1:0]) | ev_w;
    else
      ist_q <= ist_q | ev_w;
  end

  assign IRQ = |(ist_q & ien_q);
endmodule
`default_nettype wire

// ---- sqd_asserts.sv ----
// Assertions on the host-device command link
`timescale 1ns/100ps
`default_nettype none
module sqd_asserts
  import sqd_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] feat_cur,
  input wire logic reg_fis_valid,
  input wire logic sdb_valid,
  input wire logic [7:0] fis_status,
  input wire logic [7:0] fis_error,
  input wire logic [31:0] sdb_act
);
  wire take = cmd_valid && cmd_ready;
  wire fis = reg_fis_valid || sdb_valid;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  // ------------------------------------------------------------
  // Link checks
  // ------------------------------------------------------------
  a_fis_answer: assert property (take |=> reg_fis_valid)
    else $error("No register FIS after a taken command");
  a_fis_cause: assert property (reg_fis_valid |-> $past(take))
    else $error("Register FIS without a command");
  a_bad_code: assert property (take && cmd_code != SQD_CMD_SEND
    |=> fis_status == 8'h41 && fis_error == SQD_ER_ABT)
    else $error("Wrong code not aborted");
  a_bad_sub: assert property (take && feat_cur[4:0] != SQD_SUB_LOGWR
    |=> fis_status == 8'h41 && fis_error == SQD_ER_ABT)
    else $error("Reserved subcommand not aborted");
  a_busy_drop: assert property (take |=> !cmd_ready)
    else $error("Ready did not drop after take");
  a_good_status: assert property (reg_fis_valid && fis_error == 8'h0
    |-> fis_status == 8'h40)
    else $error("Accepted command status wrong");
  a_end_bits: assert property (fis |-> (fis_status & 8'hA8) == 8'h0)
    else $error("BSY, DF or DRQ set at end");
  a_err_mask: assert property (fis
    |-> (fis_error & ~SQD_ER_MASK) == 8'h0)
    else $error("Error bit outside allowed set");
  a_err_flag: assert property (reg_fis_valid
    |-> fis_status[SQD_ST_ERR] == (fis_error != 8'h0))
    else $error("ERR flag disagrees with error byte");
  a_sdb_act: assert property (sdb_valid && !fis_status[SQD_ST_ERR]
    |-> sdb_act != 32'h0)
    else $error("Good completion with empty ACT");
endmodule
`default_nettype wire

// ---- tb_queued_send_log_write_decode.sv ----
// Self-checking bench for the queued send decoder and its host
`timescale 1ns/100ps
`default_nettype none
module tb_queued_send_log_write_decode
  import sqd_pkg::*;
  ;
  logic clk, rstn, hsel, hwrite, done_valid, done_fail;
  logic hready, hresp, irq, op_valid;
  logic [31:0] haddr, hwdata, hrdata, outst, rd, acc;
  logic [1:0] htrans;
  logic [7:0] done_err, err_f, stat_f;
  logic [4:0] done_tag, op_tag;
  logic [15:0] op_count;
  logic [47:0] op_lba;
  int miscompares, cmp_count;
  sqd_if lnk ();
  sqd_dev u_sqd_dev (.CLK(clk), .RSTN(rstn), .LNK(lnk.dev),
    .OP_VALID(op_valid), .OP_TAG(op_tag), .OP_COUNT(op_count),
    .OP_LBA(op_lba), .DONE_VALID(done_valid), .DONE_TAG(done_tag),
    .DONE_FAIL(done_fail), .DONE_ERR(done_err), .ERROR_FLAGS(err_f),
    .STATUS_FLAGS(stat_f), .OUTSTANDING(outst));
  sqd_host u_sqd_host (.CLK(clk), .RSTN(rstn), .LNK(lnk.host), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp),
    .HRDATA(hrdata), .IRQ(irq));
  sqd_asserts u_sqd_asserts (.CLK(clk), .RSTN(rstn),
    .cmd_valid(lnk.cmd_valid), .cmd_ready(lnk.cmd_ready),
    .cmd_code(lnk.cmd_code), .feat_cur(lnk.feat_cur),
    .reg_fis_valid(lnk.reg_fis_valid), .sdb_valid(lnk.sdb_valid),
    .fis_status(lnk.fis_status), .fis_error(lnk.fis_error),
    .sdb_act(lnk.sdb_act));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [15:0] exp_count(input logic [15:0] c,
      input logic [4:0] s);
    // Low count bits share the byte with the subcommand
    return {c[15:5], s};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic cmd(input logic [7:0] code, input logic [4:0] sub,
      input logic [4:0] tag, input logic [15:0] cnt, input logic [47:0] lba,
      input logic good);
    int n;
    ahb(1'b1, SQD_A_CMD, {19'h0, sub, code});
    ahb(1'b1, SQD_A_TAGCNT, {11'h0, cnt, tag});
    ahb(1'b1, SQD_A_LBALO, lba[31:0]);
    ahb(1'b1, SQD_A_LBAHI, {16'h0, lba[47:32]});
    ahb(1'b1, SQD_A_ISSUE, 32'h1);
    for (n = 0; n < 20 && lnk.reg_fis_valid !== 1'b1; n++) @(negedge clk);
    chk(lnk.reg_fis_valid, 1'b1);
    chk(op_valid, good);
    if (good)
    begin
      chk(op_tag, tag);
      chk(op_count, exp_count(cnt, sub));
      chk(op_lba, lba);
    end
    @(negedge clk);
    chk(stat_f, good ? 8'h40 : 8'h41);
    chk(err_f, good ? 8'h00 : SQD_ER_ABT);
  endtask
  task automatic done(input logic [4:0] tag, input logic fail,
      input logic [7:0] err);
    int n;
    @(posedge clk);
    done_valid <= 1'b1;
    done_tag <= tag;
    done_fail <= fail;
    done_err <= err;
    @(posedge clk);
    done_valid <= 1'b0;
    for (n = 0; n < 20 && lnk.sdb_valid !== 1'b1; n++) @(negedge clk);
    chk(lnk.sdb_valid, 1'b1);
    chk(lnk.sdb_act, fail ? 32'h0 : 32'h1 << tag);
    chk(lnk.fis_status, fail ? 8'h41 : 8'h40);
    chk(lnk.fis_error, fail ? err & SQD_ER_MASK : 8'h00);
    chk(outst[tag], 1'b0);
    acc = acc | (fail ? 32'h0 : 32'h1 << tag);
  endtask
  // ------------------------------------------------------------
  // Clock, watchdog, tests
  // ------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #300000;
    miscompares++;
    end_sim;
  end
  initial
  begin
    logic [4:0] t;
    logic [47:0] l;
    logic [7:0] c;
    int i;
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    done_valid = 1'b0;
    done_tag = 5'h0;
    done_fail = 1'b0;
    done_err = 8'h0;
    acc = 32'h0;
    miscompares = 0;
    cmp_count = 0;
    void'($urandom(11795));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    ahb(1'b0, SQD_A_CMD, 32'h0);
    chk(rd, {19'h0, SQD_CMD_RST});
    ahb(1'b0, 8'h30, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, SQD_A_IEN, 32'h7);
    // Each tag is also reissued while busy, then completed
    for (i = 0; i < 8; i++)
    begin
      t = (i == 7) ? 5'h1F : 5'($urandom);
      l = (i == 0) ? '1 : 48'({$urandom, $urandom});
      cmd(SQD_CMD_SEND, SQD_SUB_LOGWR, t,
          (i == 0) ? 16'hFFFF : 16'($urandom), l, 1'b1);
      chk(outst[t], 1'b1);
      cmd(SQD_CMD_SEND, SQD_SUB_LOGWR, t, 16'h1, l, 1'b0);
      done(t, i == 3, 8'($urandom));
    end
    for (i = 0; i < 16; i++)
      if (i != 2)
        cmd(SQD_CMD_SEND, 5'(i), 5'h1, 16'h0, 48'h0, 1'b0);
    for (i = 0; i < 4; i++)
    begin
      c = (i == 0) ? 8'h63 : (i == 1) ? 8'h65 : 8'($urandom);
      if (c == SQD_CMD_SEND)
        c = 8'h00;
      cmd(c, SQD_SUB_LOGWR, 5'h2, 16'h7, 48'h5, 1'b0);
    end
    @(negedge clk);
    chk(irq, 1'b1);
    ahb(1'b0, SQD_A_ISTAT, 32'h0);
    chk(rd, 32'h7);
    ahb(1'b0, SQD_A_DONE, 32'h0);
    chk(rd, acc);
    ahb(1'b1, SQD_A_ICLR, 32'h7);
    ahb(1'b1, SQD_A_DONE, 32'hFFFFFFFF);
    ahb(1'b1, SQD_A_IEN, 32'h0);
    cmd(SQD_CMD_SEND, SQD_SUB_LOGWR, 5'h9, 16'h5, 48'h1, 1'b1);
    @(negedge clk);
    chk(irq, 1'b0);
    ahb(1'b0, SQD_A_ISTAT, 32'h0);
    chk(rd, 32'h1);
    ahb(1'b0, SQD_A_DONE, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, SQD_A_STAT, 32'h0);
    chk(rd, 32'h00004000);
    chk(hresp, 1'b0);
    end_sim;
  end
endmodule
`default_nettype wire
